// ### sdw_serial_dac_write_port.sv
// Purpose: receive-only serial command port of an 8-bit dac with double buffering
// Assumes: link pins are asynchronous and are sampled by clk; sclk well below clk/2
// Notes: analog side is represented by the output register fields
`timescale 1ns/1ps
// How it works
// [R1] three-wire link: select, clock, data in
// [R2] slave only, never drives the link
// [R3] any serial rate up to limit accepted
// [R4] input register separate from output register
// [R5] strobe low copies input to output
// [R6] strobe held low: update at select rise
// [R7] shutdown bit powers down, output high-resistance
// [R8] gain bit one unity, zero double
// [R9] code is straight binary eight bits
// [R10] reset gives known register state
// [R11] host sends 16 bits msb first
module sdw_serial_dac_write_port
  import sdw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic output_latch_strobe_n,
  output logic [7:0] analog_code,
  output logic analog_unity_gain,
  output logic analog_shutdown
);
  // reset release copy; kept outside the state struct, as are the pin sync chains
  logic [1:0] rst_sync_q;
  sdw_state_type s_q;
  sdw_state_type s_d;
  logic rst_n_int;
  // synchronised pin stages, oldest stage highest
  logic [2:0] cs_n_s;
  logic [2:0] sclk_s;
  logic [1:0] sdi_s;
  logic [1:0] latch_n_s;
  // decoded link events
  logic cs_active;
  logic cs_rise;
  logic sclk_rise;
  logic sdi_bit;
  logic latch_low;
  // frame bookkeeping
  logic frame_full;
  logic take_bit;
  logic word_ok;
  // decoded command fields
  logic [7:0] cmd_code;
  logic cmd_unity;
  logic cmd_active;
  sdw_setting_type cmd_setting;

  assign rst_n_int = rst_sync_q[1];

  // reset asserts at once and is released after two edges
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  // select pin: two flip-flops, a third for the edge; nothing drives the link
  sdw_pin_sync
  #(
    .STAGES(3),
    .IDLE(1'h1)
  )
  u_cs_sync
  (
    .clk(clk),
    .rst_n(rst_n_int),
    .pin(cs_n), // [R1] [R2]
    .stages(cs_n_s)
  );

  // serial clock pin, sampled by clk at any rate well below clk/2
  sdw_pin_sync
  #(
    .STAGES(3),
    .IDLE(1'h0)
  )
  u_sclk_sync
  (
    .clk(clk),
    .rst_n(rst_n_int),
    .pin(sclk), // [R3]
    .stages(sclk_s)
  );

  // data pin, aligned with the second serial clock stage
  sdw_pin_sync
  #(
    .STAGES(2),
    .IDLE(1'h0)
  )
  u_sdi_sync
  (
    .clk(clk),
    .rst_n(rst_n_int),
    .pin(sdi), // [R1]
    .stages(sdi_s)
  );

  // output latch strobe pin
  sdw_pin_sync
  #(
    .STAGES(2),
    .IDLE(1'h1)
  )
  u_latch_sync
  (
    .clk(clk),
    .rst_n(rst_n_int),
    .pin(output_latch_strobe_n),
    .stages(latch_n_s)
  );

  always_comb
  begin
    s_d = s_q;
    cs_active = 1'h0;
    cs_rise = 1'h0;
    sclk_rise = 1'h0;
    sdi_bit = 1'h0;
    latch_low = 1'h0;
    frame_full = 1'h0;
    take_bit = 1'h0;
    word_ok = 1'h0;
    cmd_code = 8'h00;
    cmd_unity = 1'h0;
    cmd_active = 1'h0;
    cmd_setting = s_q.input_reg;

    // events, read from the settled stages only
    cs_active = ~cs_n_s[1];
    cs_rise = cs_n_s[1] & ~cs_n_s[2];
    sclk_rise = sclk_s[1] & ~sclk_s[2];
    sdi_bit = sdi_s[1];
    latch_low = ~latch_n_s[1];

    // the counter stops at a full word, later bits are ignored
    frame_full = (s_q.count == CMD_LAST);
    take_bit = cs_active & sclk_rise & ~frame_full;

    // shift in msb first on rising serial clock edges
    if (!cs_active)
    begin
      s_d.count = 5'h00;
      s_d.shift = s_q.shift;
    end
    else if (take_bit)
    begin
      s_d.count = s_q.count + 5'h01;
      s_d.shift = {s_q.shift[14:0], sdi_bit}; // [R11]
    end
    else
    begin
      s_d.count = s_q.count;
      s_d.shift = s_q.shift;
    end

    // select rise takes the word only if at least sixteen bits came; bits after the sixteenth are dropped
    if (cs_rise)
    begin
      if (frame_full)
      begin
        word_ok = 1'h1;
      end
      else
      begin
        word_ok = 1'h0;
      end
    end
    else
    begin
      word_ok = 1'h0;
    end

    // command fields
    cmd_code = s_q.shift[POS_CODE_HI:POS_CODE_LO]; // [R9]
    cmd_unity = s_q.shift[POS_GAIN]; // [R8]
    cmd_active = s_q.shift[POS_ACTIVE]; // [R7]

    // settings as they would land in the input register
    cmd_setting.code = cmd_code;
    if (cmd_unity)
    begin
      cmd_setting.unity_gain = 1'h1;
    end
    else
    begin
      cmd_setting.unity_gain = 1'h0;
    end
    if (cmd_active)
    begin
      cmd_setting.shutdown = 1'h0;
    end
    else
    begin
      cmd_setting.shutdown = 1'h1;
    end

    // a taken word changes the input register; the output follows it only while the strobe is low
    if (word_ok)
    begin
      s_d.input_reg.code = cmd_setting.code; // [R4]
      s_d.input_reg.unity_gain = cmd_setting.unity_gain;
      s_d.input_reg.shutdown = cmd_setting.shutdown;
    end
    else
    begin
      s_d.input_reg.code = s_q.input_reg.code;
      s_d.input_reg.unity_gain = s_q.input_reg.unity_gain;
      s_d.input_reg.shutdown = s_q.input_reg.shutdown;
    end

    // strobe low copies the input register; held low it follows select rise
    if (latch_low)
    begin
      s_d.output_reg.code = s_d.input_reg.code; // [R5] [R6]
      s_d.output_reg.unity_gain = s_d.input_reg.unity_gain;
      s_d.output_reg.shutdown = s_d.input_reg.shutdown;
    end
    else
    begin
      s_d.output_reg.code = s_q.output_reg.code;
      s_d.output_reg.unity_gain = s_q.output_reg.unity_gain;
      s_d.output_reg.shutdown = s_q.output_reg.shutdown;
    end
  end

  // every state bit is loaded with its reset value by the released reset copy
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      s_q.shift <= 16'h0000;
      s_q.count <= 5'h00;
      s_q.input_reg.code <= CODE_RST; // [R10]
      s_q.input_reg.unity_gain <= GAIN_RST;
      s_q.input_reg.shutdown <= SHDN_RST;
      s_q.output_reg.code <= CODE_RST; // [R10]
      s_q.output_reg.unity_gain <= GAIN_RST;
      s_q.output_reg.shutdown <= SHDN_RST;
    end
    else
    begin
      s_q.shift <= s_d.shift;
      s_q.count <= s_d.count;
      s_q.input_reg.code <= s_d.input_reg.code;
      s_q.input_reg.unity_gain <= s_d.input_reg.unity_gain;
      s_q.input_reg.shutdown <= s_d.input_reg.shutdown;
      s_q.output_reg.code <= s_d.output_reg.code;
      s_q.output_reg.unity_gain <= s_d.output_reg.unity_gain;
      s_q.output_reg.shutdown <= s_d.output_reg.shutdown;
    end
  end

  assign analog_code = s_q.output_reg.code;
  assign analog_unity_gain = s_q.output_reg.unity_gain;
  assign analog_shutdown = s_q.output_reg.shutdown;
endmodule

// chain of flip-flops on a pin from outside the clock domain
module sdw_pin_sync
  import sdw_pkg::*;
#(
  parameter int STAGES = 2,
  parameter logic IDLE = 1'h0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic [STAGES-1:0] stages
);
  logic [STAGES-1:0] sync_q;
  logic [STAGES-1:0] sync_d;

  always_comb
  begin
    sync_d = {sync_q[STAGES-2:0], pin};
  end

  // reset to the idle level of the pin so no false edge follows reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= {STAGES{IDLE}};
    end
    else
    begin
      sync_q <= sync_d;
    end
  end

  assign stages = sync_q;
endmodule

// ### sdw_pkg.sv
// Purpose: shared constants and carrier types for the serial dac write port
// Assumes: 10 MHz core clock samples the serial link pins
// Notes: command word is 16 bits, most significant bit first
package sdw_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int CMD_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int CNT_W = 5;
  localparam logic [4:0] CMD_LAST = 5'h10;
  // field positions inside the command word
  localparam int POS_GAIN = 13;
  localparam int POS_ACTIVE = 12;
  localparam int POS_CODE_HI = 11;
  localparam int POS_CODE_LO = 4;
  // reset values
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic GAIN_RST = 1'h1;
  localparam logic SHDN_RST = 1'h1;

  typedef struct packed {
    logic [7:0] code;
    logic unity_gain;
    logic shutdown;
  } sdw_setting_type;

  typedef struct packed {
    logic [15:0] shift;
    logic [4:0] count;
    sdw_setting_type input_reg;
    sdw_setting_type output_reg;
  } sdw_state_type;
endpackage

// ### sdw_checker.sv
// Purpose: port checks
// Assumes: clk samples link
// Notes: bound to the write port module
`timescale 1ns/1ps
module sdw_checker
  import sdw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic output_latch_strobe_n,
  input wire logic [7:0] analog_code,
  input wire logic analog_unity_gain,
  input wire logic analog_shutdown
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_hold_strobe_high: assert property (output_latch_strobe_n [*6] |=>
    $stable({analog_code, analog_unity_gain, analog_shutdown}))
    else $error("outputs moved while strobe stayed high");
  a_update_after_cs: assert property ((!output_latch_strobe_n [*8] ##0
    $changed(analog_code)) |-> $past(cs_n, 2))
    else $error("held strobe update not after select rise");
  a_reset_state: assert property ($rose(rstn) |-> analog_shutdown == SHDN_RST
    && analog_unity_gain == GAIN_RST && analog_code == CODE_RST)
    else $error("bad state at reset release");
  a_reset_held: assert property (disable iff (1'b0) !rstn |=>
    analog_shutdown == SHDN_RST && analog_unity_gain == GAIN_RST && analog_code == CODE_RST)
    else $error("bad state during reset");
  a_frame_keeps_out: assert property ((!cs_n && !output_latch_strobe_n) [*8] |=>
    $stable({analog_code, analog_unity_gain, analog_shutdown}))
    else $error("outputs moved inside a frame");
  a_idle_keeps_out: assert property ((cs_n && !output_latch_strobe_n) [*8] |=>
    $stable({analog_code, analog_unity_gain, analog_shutdown}))
    else $error("outputs moved while link idle");
  cover property ($fell(analog_shutdown));
  cover property ($fell(analog_unity_gain));
  cover property ($rose(analog_shutdown));
endmodule
bind sdw_serial_dac_write_port sdw_checker chk(.*);

// ### sdw_host.sv
// Purpose: serial host model
// Assumes: 800 ns link clock
// Notes: data line inverted when idle
`timescale 1ns/1ps
module sdw_host
(
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  localparam int HALF_NS = 400;
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    sdi = 1'h0;
  end
  // n bits of w from bit 15 down, then select rises
  task send(input logic [15:0] w, input int n);
    cs_n = 1'h0;
    for (int i = 15; i > 15 - n; i--)
    begin
      sdi = w[i];
      #HALF_NS sclk = 1'h1;
      #HALF_NS sclk = 1'h0;
    end
    #HALF_NS cs_n = 1'h1;
    sdi = ~sdi;
    #HALF_NS;
  endtask
endmodule

// ### tb_top.sv
// Purpose: top bench
// Assumes: 10 MHz clock
// Notes: queue of expected outputs
`timescale 1ns/1ps
module tb_top;
  import sdw_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic lat_n = 1'h1;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic [9:0] seen;
  logic [9:0] last = {CODE_RST, GAIN_RST, SHDN_RST};
  logic [9:0] exp_v;
  logic [9:0] held;
  logic [9:0] exp_q[$];
  logic [15:0] w;
  int miscompares = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  sdw_host host(.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  sdw_serial_dac_write_port uut(.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .output_latch_strobe_n(lat_n), .analog_code(seen[9:2]), .analog_unity_gain(seen[1]),
    .analog_shutdown(seen[0]));
  task chk(input logic [9:0] s, input logic [9:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (!rstn)
    begin
      last <= seen;
    end
    else if (seen !== last)
    begin
      if (exp_q.size() == 0)
      begin
        chk(seen, last);
      end
      else
      begin
        chk(seen, exp_q.pop_front());
      end
      last <= seen;
    end
  end
  task word(input logic push);
    w = $urandom;
    w[4] = ~exp_v[2];
    exp_v = {w[11:4], w[13], ~w[12]};
    if (push)
      exp_q.push_back(exp_v);
    host.send(w, CMD_BITS);
    repeat (20) @(negedge clk);
  endtask
  initial
  begin
    w = $urandom(47);
    exp_v = {CODE_RST, GAIN_RST, SHDN_RST};
    repeat (10) @(negedge clk);
    rstn = 1'h1;
    repeat (5) @(negedge clk);
    chk(seen, {CODE_RST, GAIN_RST, SHDN_RST});
    lat_n = 1'h0;
    repeat (5) word(1'h1);
    lat_n = 1'h1;
    held = exp_v;
    word(1'h0);
    chk(seen, held);
    exp_q.push_back(exp_v);
    lat_n = 1'h0;
    repeat (20) @(negedge clk);
    chk(seen, exp_v);
    w = $urandom;
    host.send(w, 12);
    repeat (20) @(negedge clk);
    chk(seen, exp_v);
    rstn = 1'h0;
    repeat (3) @(negedge clk);
    rstn = 1'h1;
    repeat (5) @(negedge clk);
    chk(seen, {CODE_RST, GAIN_RST, SHDN_RST});
    exp_v = {CODE_RST, GAIN_RST, SHDN_RST};
    word(1'h1);
    chk(seen, exp_v);
    close_out;
  end
  initial
  begin
    #300000;
    miscompares++;
    close_out;
  end
endmodule
